/* File: inc/slw_pkg.sv */
// Constants and types shared by both ends of the serial latch write port
// How it works
// - Device samples data on serial clock rise
// - Strobe rise copies word into addressed latch
// - Host lowers strobe before shifting a word
// - Host sends one 32-bit word, four bytes
// - Host raises strobe after last byte
// - Host changes data away from rising edge
// - Phase offset comes from latch one's word
// - Phase step is full turn over denominator
// - Denominator accepted anywhere from 2 to 4095
// - Resync enabled when latch three bits 16:15 equal 10
// - Second sync pulse after load realigns phase
package slw_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 3;
  localparam int NUM_LATCH = 8;
  localparam int BYTE_W = 8;
  localparam int BYTES_PER_WORD = 4;
  // Latch one: phase word in 26:15, denominator in 14:3
  localparam int PHASE_LSB = 15;
  localparam int PHASE_W = 12;
  localparam int DENOM_LSB = 3;
  localparam int DENOM_W = 12;
  localparam logic [ADDR_W-1:0] PHASE_LATCH = 3'h1;
  localparam logic [ADDR_W-1:0] CTRL3_LATCH = 3'h3;
  localparam int CLKMODE_LSB = 15;
  localparam logic [1:0] RESYNC_MODE = 2'h2;
  localparam int DIV_LSB = 3;
  localparam int DIV_W = 12;
  localparam logic [11:0] DENOM_MIN = 12'h002;
  localparam logic [11:0] DENOM_RST = 12'h002;
  localparam logic [WORD_W-1:0] LATCH_RST = 32'h0000_0000;
  localparam int CLK_DIV_RATIO = 16;
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_LOAD, HS_DONE} slw_hstate_t;
endpackage

/* File: inc/slw_if.sv */
// Three-wire link between host and device
`timescale 1ns/100ps
`default_nettype none
interface slw_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  modport host (output sclk, output sdata, output load_strobe);
  modport dev (input sclk, input sdata, input load_strobe);
endinterface
`default_nettype wire

/* File: hdl/slw_host.sv */
// Host end: serialises one word per request
`timescale 1ns/100ps
`default_nettype none
module slw_host #(
  parameter int DIV = slw_pkg::CLK_DIV_RATIO
) (
  input wire logic clk,
  input wire logic arst_n,
  slw_if.host link,
  input wire logic req_valid,
  input wire logic [slw_pkg::WORD_W-1:0] req_word,
  output logic req_ready
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    slw_pkg::slw_hstate_t st;
    logic [15:0] div;
    logic [slw_pkg::WORD_W-1:0] sh;
    logic [5:0] cnt;
    logic sclk;
    logic sdata;
    logic le;
    logic rdy;
  } slw_hst_t;
  slw_hst_t s_r, s_nxt;
  localparam logic [15:0] HALF = 16'(DIV/2 - 1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.div = (s_r.div == HALF) ? 16'h0000 : s_r.div + 16'h0001;
    unique case (s_r.st)
      slw_pkg::HS_IDLE: begin
        s_nxt.rdy = 1'b1;
        if (req_valid && s_r.rdy) begin
          s_nxt.rdy = 1'b0;
          s_nxt.le = 1'b0;
          s_nxt.sh = req_word;
          s_nxt.cnt = 6'h00;
          s_nxt.div = 16'h0000;
          s_nxt.st = slw_pkg::HS_SHIFT;
        end
      end
      slw_pkg::HS_SHIFT: begin
        if (s_r.div == HALF) begin
          if (s_r.sclk) begin
            s_nxt.sclk = 1'b0;
            if (s_r.cnt == 6'(slw_pkg::WORD_W)) begin
              s_nxt.st = slw_pkg::HS_LOAD;
            end else begin
              // Data changes with the fall, stable a half period before rise
              s_nxt.sdata = s_r.sh[slw_pkg::WORD_W-1];
              s_nxt.sh = {s_r.sh[slw_pkg::WORD_W-2:0], 1'b0};
              s_nxt.cnt = s_r.cnt + 6'h01;
            end
          end else if (s_r.cnt == 6'h00) begin
            // First bit is set up while the clock idles low
            s_nxt.sdata = s_r.sh[slw_pkg::WORD_W-1];
            s_nxt.sh = {s_r.sh[slw_pkg::WORD_W-2:0], 1'b0};
            s_nxt.cnt = 6'h01;
          end else begin
            s_nxt.sclk = 1'b1;
          end
        end
      end
      slw_pkg::HS_LOAD: begin
        if (s_r.div == HALF) begin
          s_nxt.le = 1'b1;
          s_nxt.st = slw_pkg::HS_DONE;
        end
      end
      slw_pkg::HS_DONE: begin
        if (s_r.div == HALF) begin
          s_nxt.st = slw_pkg::HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{slw_pkg::HS_IDLE, 16'h0000, 32'h0000_0000, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk = s_r.sclk;
  assign link.sdata = s_r.sdata;
  assign link.load_strobe = s_r.le;
  assign req_ready = s_r.rdy;
endmodule
`default_nettype wire

/* File: hdl/slw_dev.sv */
// Device end: shift register, latches, phase and resync logic
`timescale 1ns/100ps
`default_nettype none
module slw_dev (
  slw_if.dev link,
  input wire logic link_arst_n,
  input wire logic sync_tick,
  output logic [slw_pkg::WORD_W-1:0] latch_word [slw_pkg::NUM_LATCH],
  output logic [slw_pkg::PHASE_W-1:0] phase_word,
  output logic [slw_pkg::DENOM_W-1:0] fraction_denominator,
  output logic [19:0] phase_step_mdeg,
  output logic resync_en,
  output logic realign
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [slw_pkg::WORD_W-1:0] sh;
    logic tgl_m;
    logic tgl_s;
    logic tgl_d;
    logic tick_m;
    logic tick_s;
    logic [1:0] sync_cnt;
    logic armed;
    logic realign;
  } slw_dst_t;
  slw_dst_t s_r, s_nxt;
  logic [slw_pkg::WORD_W-1:0] lat_r [slw_pkg::NUM_LATCH];
  logic load_tgl_r;
  logic [11:0] denom;

  // Strobe rise copies the word into its latch
  // A toggle tells the serial clock side that a load happened, since the
  // strobe itself is long gone low again by the next serial clock edge
  always_ff @(posedge link.load_strobe or negedge link_arst_n) begin
    if (!link_arst_n) begin
      for (int i = 0; i < slw_pkg::NUM_LATCH; i++) begin
        lat_r[i] <= slw_pkg::LATCH_RST;
      end
      load_tgl_r <= 1'b0;
    end else begin
      lat_r[s_r.sh[slw_pkg::ADDR_W-1:0]] <= s_r.sh;
      load_tgl_r <= ~load_tgl_r;
    end
  end

  // Shift MSB first on each rising serial clock
  // Limitation: realign only advances while the serial clock runs
  always_comb begin
    s_nxt = s_r;
    s_nxt.sh = {s_r.sh[slw_pkg::WORD_W-2:0], link.sdata};
    s_nxt.tgl_m = load_tgl_r;
    s_nxt.tgl_s = s_r.tgl_m;
    s_nxt.tgl_d = s_r.tgl_s;
    s_nxt.tick_m = sync_tick;
    s_nxt.tick_s = s_r.tick_m;
    s_nxt.realign = 1'b0;
    if (s_r.tgl_s != s_r.tgl_d) begin
      s_nxt.armed = 1'b1;
      s_nxt.sync_cnt = 2'h0;
    end else if (s_r.armed && s_r.tick_s) begin
      if (s_r.sync_cnt == 2'h1) begin
        s_nxt.realign = resync_en;
        s_nxt.armed = 1'b0;
      end
      s_nxt.sync_cnt = s_r.sync_cnt + 2'h1;
    end
  end

  always_ff @(posedge link.sclk or negedge link_arst_n) begin
    if (!link_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Denominator below minimum is clamped, 2..4095 accepted as is
  assign denom = (lat_r[slw_pkg::PHASE_LATCH][slw_pkg::DENOM_LSB +: slw_pkg::DENOM_W] < slw_pkg::DENOM_MIN) ?
                 slw_pkg::DENOM_MIN : lat_r[slw_pkg::PHASE_LATCH][slw_pkg::DENOM_LSB +: slw_pkg::DENOM_W];

  always_comb begin
    for (int i = 0; i < slw_pkg::NUM_LATCH; i++) begin
      latch_word[i] = lat_r[i];
    end
    phase_word = lat_r[slw_pkg::PHASE_LATCH][slw_pkg::PHASE_LSB +: slw_pkg::PHASE_W];
    fraction_denominator = denom;
    phase_step_mdeg = 20'(32'd360000 / {20'h0, denom});
    resync_en = (lat_r[slw_pkg::CTRL3_LATCH][slw_pkg::CLKMODE_LSB +: 2] == slw_pkg::RESYNC_MODE);
    realign = s_r.realign;
  end
endmodule
`default_nettype wire

/* File: test/slw_chk.sv */
// Wire checks on the three-wire link
`timescale 1ns/100ps
`default_nettype none
module slw_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe
);
  logic [5:0] cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ************
  // Bit counter
  // ************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= 6'h00;
    else if ($fell(load_strobe)) cnt_r <= 6'h00;
    else if ($rose(sclk)) cnt_r <= cnt_r + 6'h01;
  end
  sequence hi_half; sclk [*8]; endsequence
  sequence lo_half; !sclk [*8]; endsequence
  strobe_fall_idle_a: assert property ($fell(load_strobe) |-> !sclk) else $error("sclk high at strobe fall");
  shift_strobe_low_a: assert property ($rose(sclk) |-> !load_strobe) else $error("shift with strobe high");
  data_stable_a: assert property ($rose(sclk) |-> $stable(sdata)) else $error("data moved at rise");
  high_half_a: assert property ($rose(sclk) |-> hi_half ##1 !sclk) else $error("bad high half");
  low_half_a: assert property ($fell(sclk) |-> lo_half) else $error("short low half");
  word_bits_a: assert property ($rose(load_strobe) |-> cnt_r == 6'h20) else $error("not 32 bits");
  bit_max_a: assert property (cnt_r <= 6'h20) else $error("over 32 bits");
  strobe_after_a: assert property ($rose(load_strobe) |-> !sclk && !$past(sclk)) else $error("strobe early");
endmodule
`default_nettype wire

/* File: test/serial_latch_write_port_tb_top.sv */
// Bench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module serial_latch_write_port_tb_top;
  logic clk, arst_n, req_valid, req_ready, sync_tick;
  logic [31:0] req_word, w, s, d;
  logic [31:0] latch_word [slw_pkg::NUM_LATCH];
  logic [11:0] phase_word, fraction_denominator;
  logic [19:0] phase_step_mdeg;
  logic resync_en;
  logic [11:0] dn [4] = '{12'h000, 12'h001, 12'h002, 12'hFFF};
  int err_count = 0, comparisons = 0;
  slw_if link_if ();
  slw_host slw_host_inst (.clk(clk), .arst_n(arst_n), .link(link_if), .req_valid(req_valid),
    .req_word(req_word), .req_ready(req_ready));
  slw_dev slw_dev_inst (.link(link_if), .link_arst_n(arst_n), .sync_tick(sync_tick),
    .latch_word(latch_word), .phase_word(phase_word), .fraction_denominator(fraction_denominator),
    .phase_step_mdeg(phase_step_mdeg), .resync_en(resync_en), .realign());
  slw_chk slw_chk_inst (.clk(clk), .arst_n(arst_n), .sclk(link_if.sclk), .sdata(link_if.sdata),
    .load_strobe(link_if.load_strobe));
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Holds the request until the edge that takes it, then waits for idle
  task automatic wr(input logic [31:0] v);
    @(posedge clk);
    #1 req_valid = 1'b1;
    req_word = v;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    repeat (2000) if (req_ready !== 1'b1) @(posedge clk);
    repeat (40) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_word = 32'h0000_0000;
    sync_tick = 1'b0;
    s = 32'h0000_004C;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 20; i++) begin
      w = xs();
      sync_tick = w[31];
      // Denominator corners below, at and at the top of the accepted range
      if (i < 4) w = {w[31:15], dn[i], 3'h1};
      else w[2:0] = 3'(i);
      wr(w);
      chk(latch_word[w[2:0]], w);
      if (w[2:0] == 3'h1) begin
        d = (w[14:3] < 12'h002) ? 32'h2 : 32'(w[14:3]);
        chk(32'(fraction_denominator), d);
        chk(32'(phase_word), 32'(w[26:15]));
        chk(32'(phase_step_mdeg), 32'd360000 / d);
      end
      if (w[2:0] == 3'h3) chk(32'(resync_en), 32'(w[16:15] == 2'h2));
    end
    end_sim();
  end
endmodule
`default_nettype wire
